// file: hdl/sat_pkg.sv
package sat_pkg;

    // ----------------------------------------------------------------
    // geometry of the logical space
    // ----------------------------------------------------------------
    localparam int SAT_SLOTS = 10;
    localparam int SAT_ID_W = 4;
    localparam int SAT_TBL_W = SAT_SLOTS * SAT_ID_W;
    localparam int SAT_GROUP_BYTES = 524288;
    localparam int SAT_LOG_TOP = 5242879;
    localparam int SAT_ADDR_W = 24;
    localparam int SAT_FIELD_W = 5;
    localparam int SAT_OFS_W = 19;
    localparam int SAT_PREF_OFS_W = 12;
    localparam int SAT_BLOCK_W = 7;
    localparam int SAT_LBASE_W = 11;
    localparam int SAT_BASE_IN_W = 12;

    // ----------------------------------------------------------------
    // field positions (bit 8 of the printed address is index 23 here)
    // ----------------------------------------------------------------
    localparam int SAT_FIELD_HI = 23;
    localparam int SAT_FIELD_LO = 19;
    localparam int SAT_PREF_HI = 23;
    localparam int SAT_PREF_LO = 12;
    localparam int SAT_BIT8_POS = 11;
    localparam int SAT_LSLOT_HI = 10;
    localparam int SAT_LSLOT_LO = 7;

    // ----------------------------------------------------------------
    // identifiers, slots and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] SAT_ID_NONE = 4'h0;
    localparam logic [3:0] SAT_ID_MAX = 4'ha;
    localparam logic [3:0] SAT_LAST_SLOT = 4'h9;
    localparam logic [3:0] SAT_FIRST_SLOT = 4'h0;
    localparam logic [1:0] SAT_WRAP_LIMIT = 2'h2;
    localparam logic [SAT_TBL_W-1:0] SAT_TBL_RST = 40'h00_0000_0000;
    localparam logic [SAT_LBASE_W-1:0] SAT_LBASE_RST = 11'h000;
    localparam logic [3:0] SAT_PBASE_RST = 4'h0;

    typedef enum logic [1:0] {SAT_IDLE, SAT_STEP, SAT_HALT} sat_step_e;

    // an identifier names a real element only from 1 through A
    function automatic logic sat_valid_id(input logic [3:0] id);
        return (id != SAT_ID_NONE) && (id <= SAT_ID_MAX);
    endfunction

    // element n starts at group n-1 of the physical space
    function automatic logic [SAT_FIELD_W-1:0] sat_phys_field(input logic [3:0] id);
        logic [3:0] g;
        g = id - 4'h1;
        return {1'b0, g};
    endfunction

endpackage

// file: hdl/sat_table.sv
`timescale 1ns/1ps
module sat_table
    import sat_pkg::*;
#(
    parameter int SLOTS = SAT_SLOTS
)
(
    input wire logic clk,
    input wire logic srst,
    sat_tbl_if.tbl tp
);

    logic [3:0] slot_r [SLOTS];

    // ----------------------------------------------------------------
    // slot storage: first slot sits in the top nibble of the load word
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++)
        begin : g_slot
            always_ff @(posedge clk)
            begin
                if (srst)
                    slot_r[g] <= SAT_TBL_RST[g*4 +: 4];
                else if (tp.load)
                    slot_r[g] <= tp.data[(SLOTS-1-g)*4 +: 4]; // [RULE_04]
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // lookup: out-of-range slots read as unassigned
    // ----------------------------------------------------------------
    function automatic logic [3:0] lookup(input logic [3:0] idx);
        logic [3:0] v;
        v = SAT_ID_NONE;
        if (int'(idx) < SLOTS)
            v = slot_r[idx];
        return v;
    endfunction

    assign tp.id_a = lookup(tp.idx_a); // [RULE_03]
    assign tp.id_b = lookup(tp.idx_b); // [RULE_11]

endmodule

// file: hdl/sat_tbl_if.sv
`timescale 1ns/1ps
interface sat_tbl_if;
    import sat_pkg::*;
    logic load;
    logic [SAT_TBL_W-1:0] data;
    logic [3:0] idx_a;
    logic [3:0] idx_b;
    logic [3:0] id_a;
    logic [3:0] id_b;
    modport tbl (input load, input data, input idx_a, input idx_b, output id_a, output id_b);
    modport user (output load, output data, output idx_a, output idx_b, input id_a, input id_b);
endinterface

// file: hdl/sat_translator.sv
`timescale 1ns/1ps
// Functional notes
// RULE_01: logical space is ten consecutive 524,288-byte groups, addresses 0 to 5,242,879.
// RULE_02: logical bits 13-31 pass unchanged as the offset inside the element.
// RULE_03: logical bits 8-12 pick a slot whose identifier replaces that field.
// RULE_04: translation table holds ten four-bit physical element identifiers.
// RULE_05: normal accesses use only the translation table, never the base registers.
// RULE_06: access is preferential exactly when logical bits 8-19 are all zero.
// RULE_07: preferential address: bits 20-31 logical, 13-19 logical base, 9-12 physical base.
// RULE_08: preferential area may sit in any of 128 blocks of any element.
// RULE_09: base bit 8 is not stored but checked; one raises invalid address check.
// RULE_10: physical base refreshes whenever logical base is loaded or stepped; code refreshes it on a step only when the slot holds 1 through A.
// RULE_11: logical base bits 9-12 select a slot copied into the physical base.
// RULE_12: on element failure step slots to next configured element, keep bits 13-19.
// RULE_13: no alternate by second decode of slot 10: stop, hard stop, error log call.
// RULE_14: identifier 0 is unassigned, 1 to A are elements, B to F invalid.
// RULE_15: while stepping only identifiers 1 through A count as configured.
module sat_translator
    import sat_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic tbl_load,
    input wire logic [sat_pkg::SAT_TBL_W-1:0] tbl_data,
    input wire logic acc_req,
    input wire logic [sat_pkg::SAT_ADDR_W-1:0] acc_addr,
    input wire logic [sat_pkg::SAT_BASE_IN_W-1:0] base_data,
    input wire logic load_pref_base_op,
    input wire logic initial_program_load,
    input wire logic program_status_word_restart,
    input wire logic external_start,
    input wire logic elem_fail,
    output logic phys_valid,
    output logic [sat_pkg::SAT_ADDR_W-1:0] phys_addr,
    output logic phys_pref,
    output logic addr_check,
    output logic base_check,
    output logic [3:0] phys_base_id,
    output logic [sat_pkg::SAT_LBASE_W-1:0] logical_base,
    output logic stepping,
    output logic hard_stop,
    output logic error_log_call
);
    import sat_pkg::*;

    sat_tbl_if tif ();

    logic phys_valid_r;
    logic [SAT_ADDR_W-1:0] phys_addr_r;
    logic phys_pref_r;
    logic addr_check_r;
    logic base_check_r;
    logic [3:0] pbase_r;
    logic [SAT_LBASE_W-1:0] lbase_r;
    logic stepping_r;
    logic hard_stop_r;
    logic log_call_r;
    logic refresh_r;
    logic [1:0] wraps_r;
    sat_step_e st_r;

    logic any_load;
    logic is_pref;
    logic [SAT_FIELD_W-1:0] lfield;
    logic [3:0] lslot;
    logic [3:0] next_slot;
    logic found;
    logic give_up;
    logic step_adv;

    // ----------------------------------------------------------------
    // table hookup
    // ----------------------------------------------------------------
    sat_table #(.SLOTS(SAT_SLOTS)) u_tbl (
        .clk(clk),
        .srst(srst),
        .tp(tif.tbl)
    );

    assign tif.load = tbl_load;
    assign tif.data = tbl_data;
    assign lfield = acc_addr[SAT_FIELD_HI:SAT_FIELD_LO];
    assign tif.idx_a = lfield[3:0];
    assign lslot = lbase_r[SAT_LSLOT_HI:SAT_LSLOT_LO];
    assign tif.idx_b = lslot;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign any_load = load_pref_base_op | initial_program_load |
                      program_status_word_restart | external_start;
    assign is_pref = (acc_addr[SAT_PREF_HI:SAT_PREF_LO] == '0); // [RULE_06]
    assign next_slot = (lslot == SAT_LAST_SLOT) ? SAT_FIRST_SLOT : lslot + 4'h1;
    assign found = sat_valid_id(tif.id_b); // [RULE_15]
    assign give_up = (lslot == SAT_LAST_SLOT) && (wraps_r == SAT_WRAP_LIMIT);
    assign step_adv = (st_r == SAT_IDLE && elem_fail) ||
                      (st_r == SAT_STEP && !found && !give_up); // [RULE_12]

    // ----------------------------------------------------------------
    // address path, one cycle of latency
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            phys_valid_r <= 1'b0;
            phys_addr_r <= '0;
            phys_pref_r <= 1'b0;
            addr_check_r <= 1'b0;
        end
        else
        begin
            phys_valid_r <= acc_req;
            phys_pref_r <= acc_req & is_pref;
            if (acc_req && is_pref)
            begin
                // any of 128 blocks via the stored block number [RULE_08]
                phys_addr_r <= {sat_phys_field(pbase_r), lbase_r[SAT_BLOCK_W-1:0],
                                acc_addr[SAT_PREF_OFS_W-1:0]}; // [RULE_07]
                // mid-search the base still names the dead element, so refuse
                addr_check_r <= !sat_valid_id(pbase_r) || stepping_r; // [RULE_14]
            end
            else if (acc_req)
            begin
                // fields 10 and up lie beyond the ten groups [RULE_01]
                phys_addr_r <= {sat_phys_field(tif.id_a),
                                acc_addr[SAT_OFS_W-1:0]}; // [RULE_02] [RULE_03] [RULE_05]
                addr_check_r <= (lfield >= SAT_FIELD_W'(SAT_SLOTS)) ||
                                !sat_valid_id(tif.id_a); // [RULE_14]
            end
            else
                addr_check_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // logical base: loaded by software or stepped on failure
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            lbase_r <= SAT_LBASE_RST;
            base_check_r <= 1'b0;
            refresh_r <= 1'b0;
        end
        else
        begin
            base_check_r <= any_load & base_data[SAT_BIT8_POS]; // [RULE_09]
            refresh_r <= any_load && st_r != SAT_STEP;
            // a load mid-search is dropped so the slot walk cannot be cut short
            if (any_load && st_r != SAT_STEP)
                lbase_r <= base_data[SAT_LBASE_W-1:0]; // [RULE_09] [RULE_10]
            else if (step_adv)
                lbase_r[SAT_LSLOT_HI:SAT_LSLOT_LO] <= next_slot; // [RULE_12]
        end
    end

    // ----------------------------------------------------------------
    // physical base follows the slot that the logical base names
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            pbase_r <= SAT_PBASE_RST;
        else if (refresh_r || (st_r == SAT_STEP && found))
            pbase_r <= tif.id_b; // [RULE_10] [RULE_11]
    end

    // ----------------------------------------------------------------
    // alternate element search
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_r <= SAT_IDLE;
            wraps_r <= 2'h0;
            stepping_r <= 1'b0;
            hard_stop_r <= 1'b0;
            log_call_r <= 1'b0;
        end
        else
        begin
            log_call_r <= 1'b0;
            unique case (st_r)
                SAT_IDLE:
                    if (elem_fail)
                    begin
                        st_r <= SAT_STEP;
                        stepping_r <= 1'b1;
                        wraps_r <= (next_slot == SAT_LAST_SLOT) ? 2'h1 : 2'h0;
                    end
                SAT_STEP:
                    if (found)
                    begin
                        st_r <= SAT_IDLE;
                        stepping_r <= 1'b0;
                    end
                    else if (give_up)
                    begin
                        st_r <= SAT_HALT; // [RULE_13]
                        stepping_r <= 1'b0;
                        hard_stop_r <= 1'b1;
                        log_call_r <= 1'b1;
                    end
                    else if (next_slot == SAT_LAST_SLOT)
                        wraps_r <= wraps_r + 2'h1; // [RULE_13]
                SAT_HALT:
                    // only a fresh program load leaves the hard stop
                    if (initial_program_load)
                    begin
                        st_r <= SAT_IDLE;
                        hard_stop_r <= 1'b0;
                    end
            endcase
        end
    end

    assign phys_valid = phys_valid_r;
    assign phys_addr = phys_addr_r;
    assign phys_pref = phys_pref_r;
    assign addr_check = addr_check_r;
    assign base_check = base_check_r;
    assign phys_base_id = pbase_r;
    assign logical_base = lbase_r;
    assign stepping = stepping_r;
    assign hard_stop = hard_stop_r;
    assign error_log_call = log_call_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_offset_pass: assert property (@(posedge clk) disable iff (srst) // [RULE_02]
        acc_req && !is_pref |=> phys_addr[SAT_OFS_W-1:0] == $past(acc_addr[SAT_OFS_W-1:0]))
        else $error("offset not passed through");
    a_normal_field: assert property (@(posedge clk) disable iff (srst) // [RULE_03]
        acc_req && !is_pref |=> phys_addr[SAT_FIELD_HI:SAT_FIELD_LO] ==
            sat_phys_field($past(tif.id_a)))
        else $error("element field not translated");
    a_class_pref: assert property (@(posedge clk) disable iff (srst) // [RULE_06]
        acc_req |=> phys_pref == ($past(acc_addr[SAT_PREF_HI:SAT_PREF_LO]) == '0))
        else $error("wrong access class");
    a_pref_compose: assert property (@(posedge clk) disable iff (srst) // [RULE_07]
        acc_req && is_pref |=> phys_addr[SAT_PREF_OFS_W-1:0] ==
            $past(acc_addr[SAT_PREF_OFS_W-1:0]) &&
            phys_addr[SAT_OFS_W-1:SAT_PREF_OFS_W] == $past(lbase_r[SAT_BLOCK_W-1:0]) &&
            phys_addr[SAT_FIELD_HI:SAT_FIELD_LO] == sat_phys_field($past(pbase_r)))
        else $error("preferential address malformed");
    a_bit8_check: assert property (@(posedge clk) disable iff (srst) // [RULE_09]
        any_load |=> base_check == $past(base_data[SAT_BIT8_POS]))
        else $error("base bit 8 check wrong");
    a_base_refresh: assert property (@(posedge clk) disable iff (srst) // [RULE_10]
        any_load && st_r == SAT_IDLE ##1 1'b1 |=> phys_base_id == $past(tif.id_b))
        else $error("physical base not refreshed");
    a_step_keep: assert property (@(posedge clk) disable iff (srst) // [RULE_12]
        st_r == SAT_STEP |=> $stable(logical_base[SAT_BLOCK_W-1:0]))
        else $error("block number changed while stepping");
    a_step_found: assert property (@(posedge clk) disable iff (srst) // [RULE_15]
        st_r == SAT_STEP && found |=> phys_base_id == $past(tif.id_b) && !stepping)
        else $error("found element not taken");
    a_step_bound: assert property (@(posedge clk) disable iff (srst) // [RULE_13]
        st_r == SAT_IDLE && elem_fail |=> ##[0:24] st_r != SAT_STEP)
        else $error("stepping did not end");
    a_halt_elc: assert property (@(posedge clk) disable iff (srst) // [RULE_13]
        $rose(hard_stop) |-> error_log_call && $past(lslot) == SAT_LAST_SLOT)
        else $error("hard stop without error log call");

    // ----------------------------------------------------------------
    // checks on the access path and the search
    // ----------------------------------------------------------------
    a_valid_pulse: assert property (@(posedge clk) disable iff (srst) // [RULE_02]
        1'b1 |=> phys_valid == $past(acc_req))
        else $error("result strobe does not follow request");
    a_field_range: assert property (@(posedge clk) disable iff (srst) // [RULE_01]
        acc_req && !is_pref && lfield >= SAT_FIELD_W'(SAT_SLOTS) |=> addr_check)
        else $error("address beyond ten groups not flagged");
    a_id_invalid: assert property (@(posedge clk) disable iff (srst) // [RULE_14]
        acc_req && !is_pref && !sat_valid_id(tif.id_a) |=> addr_check)
        else $error("unassigned or invalid element not flagged");
    a_lbase_load: assert property (@(posedge clk) disable iff (srst) // [RULE_10]
        any_load && st_r != SAT_STEP |=> logical_base == $past(base_data[SAT_LBASE_W-1:0]))
        else $error("logical base not loaded");
    a_step_advance: assert property (@(posedge clk) disable iff (srst) // [RULE_12]
        step_adv && !(any_load && st_r != SAT_STEP) |=> lslot == $past(next_slot))
        else $error("search did not move to the next slot");
    a_log_call_pulse: assert property (@(posedge clk) disable iff (srst) // [RULE_13]
        error_log_call |=> !error_log_call)
        else $error("error log call longer than one cycle");
    a_halt_hold: assert property (@(posedge clk) disable iff (srst) // [RULE_13]
        hard_stop && !initial_program_load |=> hard_stop)
        else $error("hard stop left without program load");

    c_pref_access: cover property (@(posedge clk) disable iff (srst)
        acc_req && is_pref ##1 !addr_check);
    c_step_found: cover property (@(posedge clk) disable iff (srst)
        st_r == SAT_STEP && found);
    c_hard_stop: cover property (@(posedge clk) disable iff (srst) $rose(hard_stop));
    c_base_load: cover property (@(posedge clk) disable iff (srst)
        load_pref_base_op ##2 sat_valid_id(phys_base_id));
    c_slot_wrap: cover property (@(posedge clk) disable iff (srst)
        st_r == SAT_STEP && next_slot == SAT_LAST_SLOT);

endmodule

// file: tb/sat_se_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// storage elements on the physical address bus
// ----------------------------------------------------------------
module sat_storage_model
(
    input wire logic clk,
    input wire logic srst,
    input wire logic phys_valid,
    input wire logic [sat_pkg::SAT_ADDR_W-1:0] phys_addr,
    input wire logic phys_pref,
    input wire logic addr_check,
    input wire logic [3:0] fail_id,
    output logic elem_fail
);
    import sat_pkg::*;

    // element fail_id (0 = none) faults every preferential access it serves;
    // the report comes one cycle late, as a real element's check would
    initial elem_fail = 1'b0;

    always @(posedge clk)
    begin
        elem_fail <= #1 !srst && phys_valid === 1'b1 && phys_pref === 1'b1
            && addr_check === 1'b0 && fail_id != 4'h0
            && phys_addr[22:19] == fail_id - 4'h1;
    end
endmodule

// file: tb/sat_translator_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("BAD %s exp=%h got=%h", nm, (e), (g)); end end

module sat_translator_bench;
    import sat_pkg::*;

    // ----------------------------------------------------------------
    // signals and bench state
    // ----------------------------------------------------------------
    logic clk, srst, tbl_load, acc_req, elem_fail;
    logic [SAT_TBL_W-1:0] tbl_data;
    logic [SAT_ADDR_W-1:0] acc_addr, phys_addr;
    logic [SAT_BASE_IN_W-1:0] base_data;
    logic load_pref_base_op, initial_program_load, program_status_word_restart, external_start;
    logic phys_valid, phys_pref, addr_check, base_check, stepping, hard_stop;
    logic error_log_call;
    logic [3:0] phys_base_id, fail_id, pb;
    logic [SAT_LBASE_W-1:0] logical_base, lb;
    logic [39:0] cur_tbl;
    int errors, n_compared, log_call_n;
    localparam logic [11:0] BD [4] = '{12'h4ff, 12'h380, 12'h8a5, 12'h055};
    localparam logic [23:0] NA [8] = '{24'h001000, 24'h0abcde, 24'h100000,
        24'h180000, 24'h4fffff, 24'h500000, 24'h800001, 24'h27ffff};

    sat_translator i_sat_translator (.clk(clk), .srst(srst), .tbl_load(tbl_load),
        .tbl_data(tbl_data), .acc_req(acc_req), .acc_addr(acc_addr),
        .base_data(base_data), .load_pref_base_op(load_pref_base_op),
        .initial_program_load(initial_program_load),
        .program_status_word_restart(program_status_word_restart),
        .external_start(external_start), .elem_fail(elem_fail), .phys_valid(phys_valid),
        .phys_addr(phys_addr), .phys_pref(phys_pref), .addr_check(addr_check),
        .base_check(base_check), .phys_base_id(phys_base_id),
        .logical_base(logical_base), .stepping(stepping), .hard_stop(hard_stop),
        .error_log_call(error_log_call));

    sat_storage_model i_sat_storage_model (.clk(clk), .srst(srst), .phys_valid(phys_valid),
        .phys_addr(phys_addr), .phys_pref(phys_pref), .addr_check(addr_check),
        .fail_id(fail_id), .elem_fail(elem_fail));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (error_log_call === 1'b1)
            log_call_n <= log_call_n + 1;
    end

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tbl_ld(input logic [39:0] d);
        acc_req = 1'b0;
        tbl_data = d;
        tbl_load = 1'b1;
        tick;
        tbl_load = 1'b0;
        cur_tbl = d;
    endtask

    // leaves acc_req high so that calls run back to back
    task automatic acc(input logic [23:0] a);
        logic [3:0] id;
        logic pr, ck;
        logic [23:0] e;
        pr = (a[23:12] == 12'h000);
        id = pr ? pb : ((a[22:19] < 4'ha && !a[23]) ? cur_tbl[39-4*a[22:19] -: 4] : 4'h0);
        ck = (id == 4'h0) || (id > 4'ha);
        e = pr ? {1'b0, id - 4'h1, lb[6:0], a[11:0]} : {1'b0, id - 4'h1, a[18:0]};
        acc_req = 1'b1;
        acc_addr = a;
        tick;
        `CHK("valid", 1'b1, phys_valid)
        `CHK("pref", pr, phys_pref)
        `CHK("check", ck, addr_check)
        if (!ck) `CHK("paddr", e, phys_addr)
    endtask

    task automatic ld_base(input int src, input logic [11:0] d);
        acc_req = 1'b0;
        base_data = d;
        {load_pref_base_op, initial_program_load, program_status_word_restart,
            external_start} = 4'h8 >> src;
        tick;
        {load_pref_base_op, initial_program_load, program_status_word_restart,
            external_start} = 4'h0;
        lb = d[10:0];
        `CHK("lbase", lb, logical_base)
        `CHK("bchk", d[11], base_check)
        `CHK("idle", 1'b0, phys_valid)
        tick;
        pb = cur_tbl[39-4*d[10:7] -: 4];
        `CHK("pbase", pb, phys_base_id)
    endtask

    task automatic wait_step;
        int k;
        acc_req = 1'b0;
        k = 0;
        while (stepping !== 1'b1 && k < 10)
        begin
            tick;
            k++;
        end
        `CHK("stepstart", 1'b1, stepping)
        k = 0;
        while (stepping === 1'b1 && k < 40)
        begin
            tick;
            k++;
        end
        `CHK("stepend", 1'b0, stepping)
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        {srst, tbl_load, acc_req, load_pref_base_op, initial_program_load} = 5'h10;
        {program_status_word_restart, external_start} = 2'h0;
        tbl_data = 40'h0;
        acc_addr = 24'h0;
        base_data = 12'h0;
        fail_id = 4'h0;
        cur_tbl = 40'h0;
        pb = 4'h0;
        lb = 11'h0;
        errors = 0;
        n_compared = 0;
        log_call_n = 0;
        repeat (16) tick;
        srst = 1'b0;
        `CHK("reset", 46'h0, {phys_valid, phys_addr, phys_pref, addr_check, base_check, phys_base_id, logical_base, stepping, hard_stop, error_log_call})
        acc(24'h000abc);
        tbl_ld(40'h360b12457a);
        for (int i = 0; i < 4; i++)
        begin
            ld_base(i, BD[i]);
            acc(24'h000abc);
        end
        for (int i = 0; i < 8; i++)
            acc(NA[i]);
        // failing element 3 at slot 0: next configured is slot 1
        fail_id = 4'h3;
        acc(24'h000010);
        wait_step;
        lb = {4'h1, 7'h55};
        pb = 4'h6;
        `CHK("lbase", lb, logical_base)
        `CHK("pbase", pb, phys_base_id)
        // slots 2 and 3 hold 0 and b, so the search lands on slot 4
        fail_id = 4'h6;
        acc(24'h000020);
        wait_step;
        fail_id = 4'h0;
        lb = {4'h4, 7'h55};
        pb = 4'h1;
        `CHK("lbase", lb, logical_base)
        `CHK("pbase", pb, phys_base_id)
        acc(24'h000fff);
        // table emptied after the base load leaves no alternate anywhere
        tbl_ld(40'h1000000000);
        ld_base(0, 12'h02a);
        tbl_ld(40'h0);
        fail_id = 4'h1;
        acc(24'h000123);
        wait_step;
        fail_id = 4'h0;
        `CHK("hstop", 1'b1, hard_stop)
        tick;
        tick;
        `CHK("logcall", 1, log_call_n)
        `CHK("hstop", 1'b1, hard_stop)
        ld_base(1, 12'h000);
        `CHK("hclr", 1'b0, hard_stop)
        acc(24'h000001);
        acc_req = 1'b0;
        tick;
        final_report;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        final_report;
    end
endmodule
